//--- rtl/codec_pdn_pkg.sv
package codec_pdn_pkg;

  // Register offsets (byte addresses on the plain port).
  localparam logic [15:0] BLOCK_PDN_ADDR  = 16'h1101;
  localparam logic [15:0] CONV_PDN_ADDR   = 16'h1102;
  localparam logic [15:0] EVENT_STAT_ADDR = 16'h1308;

  // Field positions in block_power_down_control.
  localparam int PORT_OUTPUT_PATH_OFF_BIT = 7;
  localparam int PORT_INPUT_PATH_OFF_BIT  = 6;
  localparam int MIXER_OFF_BIT            = 5;
  localparam int EQUALIZER_OFF_BIT        = 4;
  localparam int HEADPHONE_OFF_BIT        = 3;
  localparam int RECORD_CONVERTER_OFF_BIT = 2;
  localparam int GLOBAL_SHUTDOWN_BIT      = 0;

  // Field positions in converter_and_filter_power_control.
  localparam int FILTER_CAP_CLAMP_BIT          = 4;
  localparam int RATE_CONVERTER_FORCE_OFF_BIT  = 3;
  localparam int SECOND_PORT_INTERFACE_OFF_BIT = 2;
  localparam int PLAYBACK_CONVERTER_ON_N_BIT   = 1;
  localparam int RECORD_CONVERTER_ON_N_BIT     = 0;

  // Field positions in codec_event_status.
  localparam int HEADSET_DETECT_FINISHED_BIT = 1;
  localparam int SHUTDOWN_COMPLETE_FLAG_BIT  = 0;

  // Values after reset: everything powered up, converters enabled.
  localparam logic [7:0] BLOCK_PDN_RESET = 8'h00;
  localparam logic [7:0] CONV_PDN_RESET  = 8'h03;

  // Count each path runs up to after its off bit is set; its is_off_o rises one cycle later.
  localparam logic [3:0] PATH_SETTLE_CYCLES = 4'h8;
  localparam int         NUM_PATHS          = 6;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DRAIN,
    PWR_DONE
  } pwr_state_e;

endpackage

//--- rtl/codec_power_down_sequencer.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps

// Summary of operation
// - Converter enables active high; zero powers down.
// - Six path off bits, one turns off.
// - Complete flag bit 0 after full shutdown.
// - Headset detect done bit reads zero idle.
// - Override forces converters off; clamp bit controls.
module codec_power_down_sequencer (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // Headset detection status from the analog front end
  input  wire logic        headset_detect_finished_i,
  // Power controls
  output logic      [5:0]  path_off_o,
  output logic             global_shutdown_o,
  output logic             playback_converter_off_o,
  output logic             record_converter_off_o,
  output logic             second_port_interface_off_o,
  output logic             filter_cap_clamp_o,
  output logic             shutdown_complete_o
);

  codec_pdn_pkg::reg_req_s req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  logic [7:0]               block_pdn_reg;
  logic [7:0]               conv_pdn_reg;
  logic                     done_reg;
  logic                     hs_done_reg;
  codec_pdn_pkg::pwr_state_e state_reg;
  logic [5:0]               path_req;
  logic [5:0]               path_is_off;
  logic                     all_off;
  logic [3:0]               drain_cnt_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      block_pdn_reg <= codec_pdn_pkg::BLOCK_PDN_RESET;
    end else if (req.wr && req.addr == codec_pdn_pkg::BLOCK_PDN_ADDR) begin
      block_pdn_reg <= req.wdata;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_pdn_reg <= codec_pdn_pkg::CONV_PDN_RESET;
    end else if (req.wr && req.addr == codec_pdn_pkg::CONV_PDN_ADDR) begin
      conv_pdn_reg <= req.wdata;
    end
  end

  assign path_req = {block_pdn_reg[codec_pdn_pkg::PORT_OUTPUT_PATH_OFF_BIT],
                     block_pdn_reg[codec_pdn_pkg::PORT_INPUT_PATH_OFF_BIT],
                     block_pdn_reg[codec_pdn_pkg::MIXER_OFF_BIT],
                     block_pdn_reg[codec_pdn_pkg::EQUALIZER_OFF_BIT],
                     block_pdn_reg[codec_pdn_pkg::HEADPHONE_OFF_BIT],
                     block_pdn_reg[codec_pdn_pkg::RECORD_CONVERTER_OFF_BIT]};

  for (genvar g = 0; g < codec_pdn_pkg::NUM_PATHS; g++) begin : g_path
    path_shutdown u_path (
      .clk_i    (clk_i),
      .reset_i  (reset_i),
      .off_i    (path_req[g]),
      .is_off_o (path_is_off[g])
    );
  end

  assign all_off = &path_is_off;

  // Counts cycles for which every path off bit has been held, for the completion check only.
  // It saturates, so a long shutdown cannot wrap it back below the settle time.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      drain_cnt_reg <= 4'h0;
    end else if (path_req != 6'h3f) begin
      drain_cnt_reg <= 4'h0;
    end else if (drain_cnt_reg != 4'hf) begin
      drain_cnt_reg <= drain_cnt_reg + 4'h1;
    end
  end

  // Completion waits on the global bit and every path having settled.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= codec_pdn_pkg::PWR_RUN;
    end else begin
      unique case (state_reg)
        codec_pdn_pkg::PWR_RUN: begin
          if (block_pdn_reg[codec_pdn_pkg::GLOBAL_SHUTDOWN_BIT]) begin
            state_reg <= codec_pdn_pkg::PWR_DRAIN;
          end
        end
        codec_pdn_pkg::PWR_DRAIN: begin
          if (!block_pdn_reg[codec_pdn_pkg::GLOBAL_SHUTDOWN_BIT]) begin
            state_reg <= codec_pdn_pkg::PWR_RUN;
          end else if (all_off) begin
            state_reg <= codec_pdn_pkg::PWR_DONE;
          end
        end
        codec_pdn_pkg::PWR_DONE: begin
          if (!block_pdn_reg[codec_pdn_pkg::GLOBAL_SHUTDOWN_BIT] || !all_off) begin
            state_reg <= codec_pdn_pkg::PWR_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == codec_pdn_pkg::PWR_DONE) && all_off
                  && block_pdn_reg[codec_pdn_pkg::GLOBAL_SHUTDOWN_BIT];
    end
  end

  // Detection status is registered once; it is treated as synchronous.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hs_done_reg <= 1'b0;
    end else begin
      hs_done_reg <= headset_detect_finished_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        codec_pdn_pkg::BLOCK_PDN_ADDR: rdata_o <= block_pdn_reg;
        codec_pdn_pkg::CONV_PDN_ADDR:  rdata_o <= conv_pdn_reg;
        codec_pdn_pkg::EVENT_STAT_ADDR: rdata_o <= {6'h00, hs_done_reg, done_reg};
        default:                       rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      path_off_o                  <= 6'h00;
      global_shutdown_o           <= 1'b0;
      playback_converter_off_o    <= 1'b0;
      record_converter_off_o      <= 1'b0;
      second_port_interface_off_o <= 1'b0;
      filter_cap_clamp_o          <= 1'b0;
      shutdown_complete_o         <= 1'b0;
    end else begin
      path_off_o        <= path_req;
      global_shutdown_o <= block_pdn_reg[codec_pdn_pkg::GLOBAL_SHUTDOWN_BIT];
      playback_converter_off_o <= !conv_pdn_reg[codec_pdn_pkg::PLAYBACK_CONVERTER_ON_N_BIT]
        || conv_pdn_reg[codec_pdn_pkg::RATE_CONVERTER_FORCE_OFF_BIT];
      record_converter_off_o <= !conv_pdn_reg[codec_pdn_pkg::RECORD_CONVERTER_ON_N_BIT]
        || conv_pdn_reg[codec_pdn_pkg::RATE_CONVERTER_FORCE_OFF_BIT];
      second_port_interface_off_o <= conv_pdn_reg[codec_pdn_pkg::SECOND_PORT_INTERFACE_OFF_BIT];
      filter_cap_clamp_o  <= conv_pdn_reg[codec_pdn_pkg::FILTER_CAP_CLAMP_BIT];
      shutdown_complete_o <= done_reg;
    end
  end

  AST_CONV_ZERO_OFF: assert property (@(posedge clk_i) disable iff (reset_i)
    !conv_pdn_reg[codec_pdn_pkg::PLAYBACK_CONVERTER_ON_N_BIT] |=> playback_converter_off_o)
    else $error("Playback converter not off after enable cleared.");

  AST_PATH_OFF_BIT: assert property (@(posedge clk_i) disable iff (reset_i)
    req.wr && req.addr == codec_pdn_pkg::BLOCK_PDN_ADDR
      |=> ##1 path_off_o == $past(req.wdata[7:2], 2))
    else $error("Path off outputs do not follow written bits.");

  sequence s_all_settled;
    (all_off && block_pdn_reg[codec_pdn_pkg::GLOBAL_SHUTDOWN_BIT]) [*3];
  endsequence

  AST_DONE_SETS: assert property (@(posedge clk_i) disable iff (reset_i)
    s_all_settled |=> done_reg)
    else $error("Complete flag not set after shutdown finished.");

  AST_DONE_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    req.rd && req.addr == codec_pdn_pkg::EVENT_STAT_ADDR |=> rdata_o[0] == $past(done_reg))
    else $error("Status read does not show complete flag.");

  AST_HS_READ: assert property (@(posedge clk_i) disable iff (reset_i)
    req.rd && req.addr == codec_pdn_pkg::EVENT_STAT_ADDR |=> rdata_o[1] == $past(hs_done_reg))
    else $error("Status read does not show headset detect bit.");

  AST_OVERRIDE: assert property (@(posedge clk_i) disable iff (reset_i)
    conv_pdn_reg[codec_pdn_pkg::RATE_CONVERTER_FORCE_OFF_BIT]
      |=> playback_converter_off_o && record_converter_off_o)
    else $error("Override did not force converters off.");

  AST_CLAMP: assert property (@(posedge clk_i) disable iff (reset_i)
    !conv_pdn_reg[codec_pdn_pkg::FILTER_CAP_CLAMP_BIT] |=> !filter_cap_clamp_o)
    else $error("Filter cap clamped while clamp bit clear.");

  AST_DONE_WAITS: assert property (@(posedge clk_i) disable iff (reset_i)
    done_reg |-> $past(all_off))
    else $error("Complete flag set before all paths settled.");

  sequence s_done_rises;
    $rose(done_reg);
  endsequence

  // The last path to be switched off still needs its full settle time before completion.
  AST_DONE_AFTER_SETTLE: assert property (@(posedge clk_i) disable iff (reset_i)
    s_done_rises |-> drain_cnt_reg > codec_pdn_pkg::PATH_SETTLE_CYCLES)
    else $error("Complete flag rose before the paths had time to settle.");

  AST_DONE_NEEDS_GLOBAL: assert property (@(posedge clk_i) disable iff (reset_i)
    !global_shutdown_o |=> !shutdown_complete_o)
    else $error("Complete output set while global shutdown is clear.");

endmodule // codec_power_down_sequencer

//--- rtl/path_shutdown.sv
`timescale 1ns/10ps

// Models one functional path settling after its off bit is set.
module path_shutdown (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Control
  input  wire logic off_i,
  // Status
  output logic      is_off_o
);

  logic [3:0] settle_reg;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      settle_reg <= 4'h0;
      is_off_o   <= 1'b0;
    end else if (!off_i) begin
      settle_reg <= 4'h0;
      is_off_o   <= 1'b0;
    end else if (settle_reg == codec_pdn_pkg::PATH_SETTLE_CYCLES) begin
      is_off_o <= 1'b1;
    end else begin
      settle_reg <= settle_reg + 4'h1;
    end
  end

endmodule // path_shutdown

//--- verification/codec_power_down_sequencer_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module codec_power_down_sequencer_tb;
  localparam logic [15:0] BA = codec_pdn_pkg::BLOCK_PDN_ADDR;
  localparam logic [15:0] CA = codec_pdn_pkg::CONV_PDN_ADDR;
  localparam logic [15:0] SA = codec_pdn_pkg::EVENT_STAT_ADDR;
  logic        clk_i;
  logic        reset_i;
  logic        headset;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [7:0]  rv;
  logic [5:0]  path_off;
  logic        glob;
  logic        pb_off;
  logic        rec_off;
  logic        sp_off;
  logic        clamp;
  logic        done;
  int          error_cnt;
  int          cmp_count;
  int          cyc;
  int          blk;
  int          conv;

  host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
                   .rdata_i(rdata));

  codec_power_down_sequencer i_codec_power_down_sequencer (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .headset_detect_finished_i(headset), .path_off_o(path_off),
    .global_shutdown_o(glob), .playback_converter_off_o(pb_off),
    .record_converter_off_o(rec_off), .second_port_interface_off_o(sp_off),
    .filter_cap_clamp_o(clamp), .shutdown_complete_o(done));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_outs();
    `CHK("path_off", 6'(blk >> 2), path_off)
    `CHK("global", blk[0], glob)
    `CHK("playback_off", 1'(!conv[1] || conv[3]), pb_off)
    `CHK("record_off", 1'(!conv[0] || conv[3]), rec_off)
    `CHK("second_port", conv[2], sp_off)
    `CHK("clamp", conv[4], clamp)
  endtask

  task automatic wr_chk(input logic [15:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    if (a == BA) blk = d;
    if (a == CA) conv = d;
    repeat (2) @(posedge clk_i);
    #1;
    check_outs();
    host.read_reg(BA, rv);
    `CHK("block_readback", 8'(blk), rv)
    host.read_reg(CA, rv);
    `CHK("conv_readback", 8'(conv), rv)
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    host.read_reg(a, rv);
    `CHK("rdata", e, rv)
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    reset_i = 1'b1;
    headset = 1'b0;
    blk = 0;
    conv = 3;
    void'($urandom(32'h54574c0d));
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    check_outs();
    rd_chk(BA, 8'h00);
    rd_chk(CA, 8'h03);
    rd_chk(16'h1234, 8'h00);
    wr_chk(16'h0000, 8'h5a);
    wr_chk(SA, 8'hff);
    rd_chk(SA, 8'h00);
    for (int i = 2; i < 8; i++) wr_chk(BA, 8'(1 << i));
    repeat (8) wr_chk(CA, 8'($urandom));
    wr_chk(CA, 8'h00);
    wr_chk(BA, 8'hff);
    `CHK("done_early", 1'b0, done)
    rv = 8'h00;
    for (int n = 0; n < 40 && !rv[0]; n++) host.read_reg(SA, rv);
    `CHK("status", 8'h01, rv)
    `CHK("done", 1'b1, done)
    @(posedge clk_i);
    headset <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd_chk(SA, 8'h03);
    @(posedge clk_i);
    headset <= 1'b0;
    wr_chk(CA, 8'h9c);
    `CHK("clamp_before_clock_stop", 1'b1, clamp)
    `CHK("done_before_supply_off", 1'b1, done)
    wr_chk(CA, 8'h8c);
    wr_chk(BA, 8'hfe);
    repeat (2) @(posedge clk_i);
    `CHK("done_clear", 1'b0, done)
    rd_chk(SA, 8'h00);
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    blk = 0;
    conv = 3;
    #1;
    check_outs();
    rd_chk(CA, 8'h03);
    rd_chk(BA, 8'h00);
    complete_run();
  end
endmodule // codec_power_down_sequencer_tb

//--- verification/host_model.sv
`timescale 1ns/10ps

// Host side of the register port.
// Idle lines carry inverted values, so a stale address can never pass as a live request.
module host_model (
  // Clock
  input  wire logic        clk_i,
  // Register port
  output logic      [15:0] addr_o,
  output logic      [7:0]  wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [7:0]  rdata_i
);
  initial begin
    addr_o  = 16'h0000;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule // host_model
